//--- msb_bridge.sv
// Multidrop scan bridge front end: bridge TAP, selection, local chain port network
// and a logging FIFO for mode register updates.
// Assumes the backplane scan pins and slot inputs are synchronous to clk,
// and that the test clock runs much slower than clk.
//
// Overview of operation
// - Unselected bridge follows the TAP protocol but obeys only a matching address phase.
// - Unselected bridge keeps data registers and local ports off the backplane path.
// - Selection only after a matching address phase; only then selected instructions count.
// - Selected with all ports parked, path is only the chosen bridge register.
// - Unparked path: data-in, bridge register, then a retiming bit and local ring per port, data-out.
// - One retiming bit sits at the head of each local port's path.
// - Retiming bits capture the preceding stage's serial output on the test clock falling edge.
// - Singly selected bridge behaves as a standard boundary-scan device.
// - Backplane mode-select steps the bridge TAP and, while selected, each unparked local TAP ring.
// - Active-low test reset initialises the bridge logic at once.
// - Bridge address comes from six static slot identification inputs.
// - Local output enable high puts all local port outputs in high impedance.
// - Backplane data-out returns bridge register data and local ring data.
// - Bit 0 of every bridge register is the least significant, shifted first.
// - Each of the three local ports has its own serial data output.
// - Each local port has clock, mode select, data out and data in.
// - A parked port holds its local mode-select output constant.
// - Each local clock output is a copy of the backplane clock registered on clk.
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Synchronous FIFO with valid and ready on both sides
// ----------------------------------------------------------------
module msb_fifo
  import msb_pkg::*;
#(
  parameter int WIDTH = OBS_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // Handshakes on each side, and the read pointer and fill level after this cycle.
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != DEPTH_CNT);
  assign next_rd_ptr = rd_ptr + {{(AW-1){1'b0}}, pop};
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      // Registered read side; a word pushed into an emptying FIFO bypasses the array.
      out_valid <= (next_count != '0);
      if (push && wr_ptr == next_rd_ptr) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[next_rd_ptr];
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// Bridge top
// ----------------------------------------------------------------
module msb_bridge
  import msb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tck_b,
  input wire logic tms_b,
  input wire logic tdi_b,
  input wire logic trst_n,
  input wire logic [SLOT_W-1:0] slot_id,
  input wire logic oe_n,
  input wire logic [NUM_PORTS-1:0] tdi_l,
  output logic tdo_b,
  output logic tdo_b_oe,
  output msb_lp_s [NUM_PORTS-1:0] lp_out,
  output logic obs_valid,
  input wire logic obs_ready,
  output msb_obs_s obs_data,
  output logic obs_room
);

  // TAP next state for a given mode-select level.
  function automatic msb_tap_e tap_next(input msb_tap_e s, input logic tms);
    case (s)
      ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
      ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
      default: tap_next = ST_TLR;
    endcase
  endfunction

  logic tck_q;
  logic tck_rise;
  logic tck_fall;
  msb_tap_e tap;
  logic selected;
  logic [IR_W-1:0] ir;
  logic [IR_W-1:0] ir_sh;
  logic [MODE_W-1:0] mode;
  logic [MODE_W-1:0] mode_sh;
  logic byp;
  logic [NUM_PORTS-1:0] unparked;
  logic bridge_out;
  logic [NUM_PORTS-1:0] next_tdo_l;
  logic next_tdo_b;
  logic in_shift;
  logic addr_match;
  logic log_push;
  logic log_ready;
  logic bridge_rst;

  // Backplane clock edges, seen one system clock after the pin moves.
  assign tck_rise = tck_b && !tck_q;
  assign tck_fall = !tck_b && tck_q;
  assign bridge_rst = reset || !trst_n;
  assign in_shift = (tap == ST_SH_DR) || (tap == ST_SH_IR);
  assign addr_match = (ir_sh == {ADDR_TOP, slot_id});
  assign log_push = tck_rise && selected && (tap == ST_UPD_DR) && (ir == IR_MODE);

  // Previous backplane clock level for edge detection; the local clocks are separate copies.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck_b;
    end
  end

  // Bridge TAP controller steps on each rising test clock edge.
  always_ff @(posedge clk or posedge bridge_rst or negedge trst_n) begin
    if (bridge_rst || !trst_n) begin
      tap <= ST_TLR;
    end else if (tck_rise) begin
      tap <= tap_next(tap, tms_b);
    end
  end

  // Selection controller: address phase selects, return-to-wait deselects.
  always_ff @(posedge clk or posedge bridge_rst or negedge trst_n) begin
    if (bridge_rst || !trst_n) begin
      selected <= 1'b0;
      ir <= IR_BYPASS;
    end else if (tck_rise && tap == ST_TLR) begin
      ir <= IR_BYPASS;
    end else if (tck_rise && tap == ST_UPD_IR) begin
      if (ir_sh == IR_RETURN_TO_WAIT) begin
        selected <= 1'b0;
        ir <= IR_BYPASS;
      end else if (!selected) begin
        if (addr_match) begin
          selected <= 1'b1;
          ir <= IR_BYPASS;
        end
      end else begin
        ir <= ir_sh;
      end
    end
  end

  // Instruction shift register, shifting towards bit 0.
  always_ff @(posedge clk or posedge bridge_rst or negedge trst_n) begin
    if (bridge_rst || !trst_n) begin
      ir_sh <= IR_CAPTURE;
    end else if (tck_rise && tap == ST_CAP_IR) begin
      ir_sh <= IR_CAPTURE;
    end else if (tck_rise && tap == ST_SH_IR) begin
      ir_sh <= {tdi_b, ir_sh[IR_W-1:1]};
    end
  end

  // Data registers shift only while selected.
  always_ff @(posedge clk or posedge bridge_rst or negedge trst_n) begin
    if (bridge_rst || !trst_n) begin
      mode_sh <= MODE_RESET;
      mode <= MODE_RESET;
      byp <= 1'b0;
    end else if (tck_rise && selected) begin
      if (tap == ST_CAP_DR) begin
        byp <= 1'b0;
        mode_sh <= mode;
      end else if (tap == ST_SH_DR) begin
        byp <= tdi_b;
        mode_sh <= {tdi_b, mode_sh[MODE_W-1:1]};
      end else if (tap == ST_UPD_DR && ir == IR_MODE) begin
        mode <= mode_sh;
      end
    end
  end

  // Park state per port; park and unpark act on ports picked in the mode register.
  always_ff @(posedge clk or posedge bridge_rst or negedge trst_n) begin
    if (bridge_rst || !trst_n) begin
      unparked <= '0;
    end else if (!selected) begin
      unparked <= unparked;
    end else if (tck_rise && tap == ST_UPD_IR) begin
      if (ir_sh == IR_UNPARK) begin
        unparked <= unparked | mode[NUM_PORTS-1:0];
      end else if (ir_sh == IR_PARK) begin
        unparked <= unparked & ~mode[NUM_PORTS-1:0];
      end
    end
  end

  // Serial path: bridge register, then each unparked ring behind its retiming bit.
  always_comb begin
    logic s;
    s = 1'b0;
    bridge_out = (tap == ST_SH_IR) ? ir_sh[0] : ((ir == IR_MODE) ? mode_sh[0] : byp);
    s = bridge_out;
    for (int i = 0; i < NUM_PORTS; i++) begin
      next_tdo_l[i] = s;
      if (selected && unparked[i]) begin
        s = tdi_l[i];
      end
    end
    next_tdo_b = s;
  end

  // Falling edge registers for the backplane data out and its enable.
  always_ff @(posedge clk or posedge bridge_rst or negedge trst_n) begin
    if (bridge_rst || !trst_n) begin
      tdo_b <= 1'b0;
      tdo_b_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_b <= next_tdo_b;
      tdo_b_oe <= in_shift && (selected || tap == ST_SH_IR);
    end
  end

  // Local port pins; each data out is also the retiming bit of the stage before it.
  always_ff @(posedge clk or posedge bridge_rst or negedge trst_n) begin
    if (bridge_rst || !trst_n) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        lp_out[i].tck <= 1'b0;
        lp_out[i].tms <= TMS_RESET_LVL;
        lp_out[i].tdo <= 1'b0;
        lp_out[i].oe <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        lp_out[i].tck <= tck_b;
        lp_out[i].oe <= !oe_n;
        if (tck_fall) begin
          lp_out[i].tdo <= next_tdo_l[i];
        end
        if (selected && unparked[i]) begin
          lp_out[i].tms <= tms_b;
        end else begin
          lp_out[i].tms <= lp_out[i].tms;
        end
      end
    end
  end

  // Room flag for the update log, registered for a clean output.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      obs_room <= 1'b0;
    end else begin
      obs_room <= log_ready;
    end
  end

  // Log of mode register updates; an update while full is dropped.
  msb_fifo #(
    .WIDTH(OBS_W),
    .DEPTH(FIFO_DEPTH)
  ) u_log (
    .clk(clk),
    .reset(bridge_rst),
    .in_valid(log_push),
    .in_ready(log_ready),
    .in_data({unparked, mode_sh}),
    .out_valid(obs_valid),
    .out_ready(obs_ready),
    .out_data(obs_data)
  );
endmodule

//--- msb_pkg.sv
// Package for the multidrop scan bridge front end.
// Assumes one system clock; all scan pins arrive already synchronous to it.
package msb_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 3;
  localparam int SLOT_W = 6;
  localparam int IR_W = 8;
  localparam int MODE_W = 8;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Instruction codes and capture values
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
  localparam logic [IR_W-1:0] IR_BYPASS = 8'hFF;
  localparam logic [IR_W-1:0] IR_RETURN_TO_WAIT = 8'hE0;
  localparam logic [IR_W-1:0] IR_MODE = 8'hE1;
  localparam logic [IR_W-1:0] IR_UNPARK = 8'hE2;
  localparam logic [IR_W-1:0] IR_PARK = 8'hE3;
  localparam logic [IR_W-SLOT_W-1:0] ADDR_TOP = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
  localparam logic TMS_RESET_LVL = 1'b1;

  // TAP controller states.
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } msb_tap_e;

  // Output pins of one local chain port.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdo;
    logic oe;
  } msb_lp_s;

  // Word logged on every mode register update that finds room in the log.
  typedef struct packed {
    logic [NUM_PORTS-1:0] unparked;
    logic [MODE_W-1:0] mode;
  } msb_obs_s;

  localparam int OBS_W = $bits(msb_obs_s);

endpackage

//--- msb_bridge_assertions.sv
// Checker for the scan bridge top: local port pins, backplane data-out and the log FIFO.
// Assumes it is bound into the bridge top; tck_b is slow against clk.
`timescale 1ns/100ps
module msb_bridge_assertions
  import msb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tck_b,
  input wire logic tms_b,
  input wire logic trst_n,
  input wire logic oe_n,
  input wire logic tdo_b,
  input wire logic tdo_b_oe,
  input wire msb_lp_s [NUM_PORTS-1:0] lp_out,
  input wire logic obs_valid,
  input wire logic obs_ready,
  input wire msb_obs_s obs_data
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Both resets clear the scan logic, so checks pause while either is active.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset || !trst_n);

  a_lp_clock_copy: assert property ($past(trst_n) && !$past(reset) |->
    lp_out[0].tck == $past(tck_b) && lp_out[1].tck == $past(tck_b) && lp_out[2].tck == $past(tck_b))
    else $error("local clock is not the backplane clock");
  a_port_oe_follow: assert property ($past(trst_n) && !$past(reset) |->
    lp_out[0].oe == !$past(oe_n) && lp_out[1].oe == !$past(oe_n) && lp_out[2].oe == !$past(oe_n))
    else $error("local enable does not follow oe_n");
  a_tms_follow: assert property ($changed(lp_out[0].tms) |-> lp_out[0].tms == $past(tms_b))
    else $error("local mode select moved on its own");
  a_tdo_fall_only: assert property ($changed(tdo_b) |->
    (!$past(tck_b) && $past(tck_b, 2)) || (!$past(tck_b, 2) && $past(tck_b, 3)))
    else $error("data out changed away from a clock fall");
  a_ltdo_fall_only: assert property ($changed(lp_out[0].tdo) |->
    (!$past(tck_b) && $past(tck_b, 2)) || (!$past(tck_b, 2) && $past(tck_b, 3)))
    else $error("local data out changed away from a clock fall");
  a_tdo_oe_edge: assert property ($changed(tdo_b_oe) |->
    $past(tck_b) != $past(tck_b, 2) || $past(tck_b, 2) != $past(tck_b, 3) || $past(tck_b, 3) != $past(tck_b, 4))
    else $error("data out enable changed without a clock edge");
  a_reset_values: assert property ($fell(reset) || $rose(trst_n) |->
    !tdo_b && !tdo_b_oe && lp_out[0].tms && lp_out[1].tms && lp_out[2].tms)
    else $error("wrong values after reset");
  a_fifo_hold: assert property (obs_valid && !obs_ready |=> obs_valid && $stable(obs_data))
    else $error("log word dropped while stalled");
endmodule

bind msb_bridge msb_bridge_assertions msb_bridge_assertions_inst (.clk, .reset, .tck_b, .tms_b, .trst_n, .oe_n,
  .tdo_b, .tdo_b_oe, .lp_out, .obs_valid, .obs_ready, .obs_data);

//--- msb_master_model.sv
// Partner model: the system test master making test clock, mode select and data in.
// Assumes the bench clock; each test clock half period is four clk cycles.
`timescale 1ns/100ps
module msb_master_model (
  input wire logic clk,
  input wire logic tdo_b,
  input wire logic tdo_b_oe,
  output logic tck_b,
  output logic tms_b,
  output logic tdi_b
);
  logic last = 1'h0;

  // ----------------------------------------------------------------
  // Test clock cycles
  // ----------------------------------------------------------------
  // Idle pins: clock stands low, mode select high, data in at its pull-up level.
  initial begin
    tck_b = 1'h0;
    tms_b = 1'h1;
    tdi_b = 1'h1;
  end

  // One clock period; a floating data-out reads as the inverse of the last bit.
  task automatic pulse(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk);
    #1 tms_b = tms;
    tdi_b = tdi;
    repeat (3) @(posedge clk);
    #1 tck_b = 1'h1;
    tdo = tdo_b_oe ? tdo_b : !last;
    last = tdo;
    repeat (4) @(posedge clk);
    #1 tck_b = 1'h0;
  endtask

  // Scan from idle through the IR or DR column back to idle, bit 0 first.
  task automatic scan(input logic ir, input logic [4:0] n, input logic [15:0] din, output logic [15:0] dout);
    logic b;
    dout = '0;
    pulse(1'h1, 1'h1, b);
    if (ir) begin
      pulse(1'h1, 1'h1, b);
    end
    pulse(1'h0, 1'h1, b);
    pulse(1'h0, 1'h1, b);
    for (int i = 0; i < int'(n); i++) begin
      pulse(i == int'(n) - 1, din[i], dout[i]);
    end
    pulse(1'h1, 1'h1, b);
    pulse(1'h0, 1'h1, b);
  endtask
endmodule

//--- msb_bridge_tb_top.sv
// Bench top for the scan bridge: a table of scans, then log FIFO, enable and reset cases.
// Assumes the master model and checker files are compiled first.
`timescale 1ns/100ps
`define CHK(nm, ex, sn) begin checks++; if ((sn) !== (ex)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, ex, sn); end end
module msb_bridge_tb_top
  import msb_pkg::*;
;
  localparam logic [SLOT_W-1:0] SLOT = 6'h2A; // Arbitrary slot address.
  localparam logic [15:0] ADDR = {8'h00, ADDR_TOP, SLOT};
  localparam int WD_NS = 200000;
  typedef struct packed {
    logic ir;
    logic [4:0] n;
    logic [15:0] din;
    logic [15:0] dout;
    logic [15:0] mask;
    logic push;
    logic [OBS_W-1:0] obs;
  } msb_row_s;
  logic clk, reset, trst_n, oe_n, obs_ready, tck_b, tms_b, tdi_b, tdo_b, tdo_b_oe, obs_valid, obs_room;
  logic [NUM_PORTS-1:0] tdi_l;
  msb_lp_s [NUM_PORTS-1:0] lp_out;
  msb_obs_s obs_data;
  logic [15:0] q;
  int fail_count, checks;
  msb_row_s rows [12] = '{
    '{1'h1, 5'h08, 16'h00E1, 16'h0001, 16'h00FF, 1'h0, 11'h000},
    '{1'h0, 5'h08, 16'h0007, 16'h00AA, 16'h00FF, 1'h0, 11'h000},
    '{1'h1, 5'h08, ADDR, 16'h0001, 16'h00FF, 1'h0, 11'h000},
    '{1'h1, 5'h10, 16'hE15A, 16'h5A01, 16'hFFFF, 1'h0, 11'h000},
    '{1'h0, 5'h08, 16'h0005, 16'h0000, 16'h00FF, 1'h1, 11'h005},
    '{1'h1, 5'h08, 16'h00E2, 16'h0001, 16'h00FF, 1'h0, 11'h000},
    '{1'h1, 5'h10, 16'hE1C3, 16'h0C04, 16'hFFFC, 1'h0, 11'h000},
    '{1'h0, 5'h08, 16'h000F, 16'h0014, 16'h00FC, 1'h1, 11'h50F},
    '{1'h1, 5'h10, 16'hE300, 16'h0004, 16'hFFFC, 1'h0, 11'h000},
    '{1'h1, 5'h10, 16'hE000, 16'h0001, 16'hFFFF, 1'h0, 11'h000},
    '{1'h1, 5'h08, 16'h00E1, 16'h0001, 16'h00FF, 1'h0, 11'h000},
    '{1'h0, 5'h08, 16'h002B, 16'h00AA, 16'h00FF, 1'h0, 11'h000}};

  msb_bridge msb_bridge_inst (.clk, .reset, .tck_b, .tms_b, .tdi_b, .trst_n, .slot_id(SLOT), .oe_n, .tdi_l,
    .tdo_b, .tdo_b_oe, .lp_out, .obs_valid, .obs_ready, .obs_data, .obs_room);
  msb_master_model msb_master_model_inst (.clk, .tdo_b, .tdo_b_oe, .tck_b, .tms_b, .tdi_b);

  // Each local ring is a bare wire; a released port reads its pull-up level.
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      tdi_l[i] = lp_out[i].oe ? lp_out[i].tdo : 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  // System clock at 125 MHz.
  initial begin
    clk = 1'h0;
    forever #4 clk = !clk;
  end

  // Cuts a hang short well past the expected run time.
  initial begin
    #(WD_NS);
    fail_count++;
    test_done();
  end

  // Takes one log word and checks it.
  task automatic pop(input logic [OBS_W-1:0] e);
    int w;
    w = 0;
    while (obs_valid !== 1'h1 && w < 20) begin
      @(posedge clk);
      #1 w++;
    end
    `CHK("obs_valid", 1'h1, obs_valid)
    `CHK("obs_data", e, obs_data)
    @(posedge clk);
    #1 obs_ready = 1'h1;
    @(posedge clk);
    #1 obs_ready = 1'h0;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Table of scans first, then the awkward cases by hand.
  initial begin
    reset = 1'h1;
    trst_n = 1'h1;
    oe_n = 1'h0;
    obs_ready = 1'h0;
    fail_count = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    #1 reset = 1'h0;
    msb_master_model_inst.pulse(1'h0, 1'h1, q[0]);
    foreach (rows[r]) begin
      msb_master_model_inst.scan(rows[r].ir, rows[r].n, rows[r].din, q);
      `CHK("scan_out", rows[r].dout & rows[r].mask, q & rows[r].mask)
      if (rows[r].push) begin
        pop(rows[r].obs);
      end else begin
        `CHK("obs_valid", 1'h0, obs_valid)
      end
    end
    `CHK("parked_tms", 1'h1, lp_out[1].tms)
    msb_master_model_inst.scan(1'h1, 5'h08, ADDR, q);
    msb_master_model_inst.scan(1'h1, 5'h08, 16'h00E1, q);
    for (int k = 0; k < 17; k++) begin
      msb_master_model_inst.scan(1'h0, 5'h08, 16'(k), q);
    end
    `CHK("obs_room", 1'h0, obs_room)
    for (int k = 0; k < 16; k++) begin
      pop({3'h0, 8'(k)});
    end
    repeat (4) @(posedge clk);
    #1 `CHK("obs_empty", 2'h1, {obs_valid, obs_room})
    oe_n = 1'h1;
    repeat (2) @(posedge clk);
    #1 `CHK("port_oe", 3'h0, {lp_out[2].oe, lp_out[1].oe, lp_out[0].oe})
    oe_n = 1'h0;
    repeat (3) @(posedge clk);
    #1 trst_n = 1'h0;
    #1 `CHK("async_reset", 2'h0, {lp_out[0].oe, tdo_b_oe})
    @(posedge clk);
    #1 trst_n = 1'h1;
    // The bridge was selected with the mode instruction; after the test reset a data scan must not log.
    msb_master_model_inst.pulse(1'h0, 1'h1, q[0]);
    msb_master_model_inst.scan(1'h0, 5'h08, 16'h0033, q);
    `CHK("reset_unselects", 1'h0, obs_valid)
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
